// [dv/ohi_host_if_test.sv]
// self-checking bench for the display host port over all four bus types
// assumes the host model is compiled first and drives the pins it owns
`timescale 1ns/100ps
module ohi_host_if_test
  import ohi_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reset_in_n;
  logic bus_strap_low;
  logic bus_strap_high;
  logic [7:0] rd_data;
  logic cs_n, dc_sel, rw_wr_n, e_rd_n, rd_start, chip_init, sda;
  logic [7:0] h_drv, h_oe, bus_lvl, host_data_bus_out, host_data_bus_oe;
  ohi_write_s host_wr;
  ohi_mode_e bus_mode;
  ohi_write_s wr_q[$]; // writes handed to the core, in order
  int rd_cnt = 0;
  int err_count = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  ohi_host_if u_dut (.clk(clk), .reset(reset), .cs_n(cs_n), .reset_in_n(reset_in_n), .dc_sel(dc_sel),
    .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .bus_strap_low(bus_strap_low), .bus_strap_high(bus_strap_high),
    .host_data_bus_in(bus_lvl), .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .rd_data(rd_data), .rd_start(rd_start), .host_wr(host_wr), .chip_init(chip_init), .bus_mode(bus_mode));

  ohi_host_model u_host (.clk(clk), .bus_lvl(bus_lvl), .cs_n(cs_n), .dc_sel(dc_sel), .rw_wr_n(rw_wr_n),
    .e_rd_n(e_rd_n), .d_drv(h_drv), .d_oe(h_oe));

  // wire level; undriven pins sit low, joined i2c data pins pulled up
  always_comb begin
    for (int i = 0; i < 8; i++) bus_lvl[i] = host_data_bus_oe[i] ? host_data_bus_out[i] : (h_oe[i] & h_drv[i]);
    sda = (host_data_bus_oe[2] ? host_data_bus_out[2] : 1'b1) & (h_oe[1] ? h_drv[1] : 1'b1);
    if ({bus_strap_high, bus_strap_low} == STRAP_I2C) bus_lvl[2:1] = {sda, sda};
  end

  // collect every write pulse and read start
  always @(posedge clk) begin
    if (host_wr.valid === 1'b1) wr_q.push_back(host_wr);
    if (rd_start === 1'b1) rd_cnt++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pops the oldest write; an empty queue reads as all zero
  task automatic chk_wr(input logic dc, input logic [7:0] d);
    ohi_write_s got;
    got = '0;
    if (wr_q.size() > 0) got = wr_q.pop_front();
    num_checks++;
    if (got !== {1'b1, dc, d}) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, {1'b1, dc, d});
    end
  endtask

  // straps change only under chip reset, then are latched on release
  task automatic set_mode(input logic [1:0] s);
    {bus_strap_high, bus_strap_low} = s;
    reset_in_n = 1'b0;
    u_host.park(s);
    u_host.tick(8);
    chk_byte({7'h00, chip_init}, 8'h01);
    reset_in_n = 1'b1;
    u_host.tick(12);
    chk_byte({7'h00, chip_init}, 8'h00);
    chk_byte({6'h00, bus_mode}, {6'h00, s});
  endtask

  task automatic t_par(input logic i80);
    logic [7:0] q;
    int r0;
    set_mode(i80 ? STRAP_8080 : STRAP_6800);
    // a different read byte per bus type, so a stuck read path shows
    rd_data = i80 ? 8'h3C : 8'hA5;
    r0 = rd_cnt;
    u_host.par_xfer(i80, 1'b1, 1'b0, 1'b0, 8'hA3, q);
    chk_wr(1'b0, 8'hA3);
    u_host.par_xfer(i80, 1'b1, 1'b0, 1'b1, 8'h5C, q);
    chk_wr(1'b1, 8'h5C);
    u_host.par_xfer(i80, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk_byte(q, i80 ? 8'h3C : 8'hA5);
    chk_byte(8'(rd_cnt - r0), 8'h01);
    chk_byte(host_data_bus_oe, 8'h00);
    u_host.par_xfer(i80, 1'b0, 1'b0, 1'b1, 8'h77, q);
    u_host.par_xfer(i80, 1'b0, 1'b1, 1'b1, 8'h00, q);
    chk_byte(q, 8'h00);
    chk_byte(8'(wr_q.size() + rd_cnt - r0), 8'h01);
  endtask

  task automatic t_spi();
    set_mode(STRAP_SPI);
    u_host.spi_byte(1'b1, 1'b0, 8'hA1);
    u_host.spi_byte(1'b1, 1'b1, 8'h3A);
    chk_wr(1'b0, 8'hA1);
    chk_wr(1'b1, 8'h3A);
    u_host.spi_byte(1'b0, 1'b1, 8'hC3);
    chk_byte(8'(wr_q.size()), 8'h00);
    chk_byte(host_data_bus_oe, 8'h00);
  endtask

  task automatic i2c_send(input logic [7:0] b, input logic e_ack);
    logic ack;
    u_host.i2c_byte(b, ack);
    chk_byte({7'h00, ack}, {7'h00, e_ack});
  endtask

  task automatic t_i2c();
    set_mode(STRAP_I2C);
    // continuation set: control, data, control, data
    u_host.i2c_start(1'b0);
    i2c_send(8'h78, 1'b1);
    i2c_send(8'h80, 1'b1);
    i2c_send(8'hAE, 1'b1);
    i2c_send(8'h40, 1'b1);
    i2c_send(8'h12, 1'b1);
    u_host.i2c_stop();
    chk_wr(1'b0, 8'hAE);
    chk_wr(1'b1, 8'h12);
    // continuation clear: every later byte is data
    u_host.i2c_start(1'b1);
    i2c_send(8'h7A, 1'b1);
    i2c_send(8'h40, 1'b1);
    i2c_send(8'h34, 1'b1);
    i2c_send(8'h56, 1'b1);
    u_host.i2c_stop();
    chk_wr(1'b1, 8'h34);
    chk_wr(1'b1, 8'h56);
    // address of the other select pin setting is ignored
    u_host.i2c_start(1'b1);
    i2c_send(8'h78, 1'b0);
    i2c_send(8'h00, 1'b0);
    u_host.i2c_stop();
    chk_byte(8'(wr_q.size()), 8'h00);
    chk_byte(host_data_bus_oe, 8'h00);
  endtask

  initial begin
    // chip reset released and straps at serial until the first scenario
    reset_in_n = 1'b1;
    bus_strap_low = 1'b0;
    bus_strap_high = 1'b0;
    rd_data = 8'h00;
    u_host.tick(8);
    reset = 1'b0;
    u_host.tick(8);
    t_par(1'b0);
    t_par(1'b1);
    t_spi();
    t_i2c();
    summarize();
  end

  // whole run needs about 1800 cycles; cut a hang well after that
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule

// [dv/ohi_host_model.sv]
// host microcontroller model that masters the display host port pins
// assumes bus_lvl is the resolved data bus level worked out by the bench
`timescale 1ns/100ps
module ohi_host_model
  import ohi_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] bus_lvl,
  output logic cs_n,
  output logic dc_sel,
  output logic rw_wr_n,
  output logic e_rd_n,
  output logic [7:0] d_drv,
  output logic [7:0] d_oe
);
  // every pin moves on a falling edge only
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // idle levels for one bus type; serial link clocks stand still
  task automatic park(input logic [1:0] s);
    cs_n = 1'b1;
    dc_sel = 1'b0;
    rw_wr_n = 1'b1;
    e_rd_n = (s == STRAP_8080);
    d_drv = (s == STRAP_I2C) ? 8'h01 : 8'h00;
    d_oe = (s == STRAP_I2C) ? 8'h01 : (s == STRAP_SPI) ? 8'h03 : 8'hFF;
  endtask

  // one parallel cycle; strobe held 8 clk, data held 6 clk past it
  task automatic par_xfer(input logic i80, input logic sel, input logic rd, input logic dc,
                          input logic [7:0] wd, output logic [7:0] q);
    cs_n = ~sel;
    dc_sel = dc;
    d_drv = wd;
    d_oe = rd ? 8'h00 : 8'hFF;
    if (!i80) rw_wr_n = rd;
    tick(4);
    if (!i80) e_rd_n = 1'b1;
    else if (rd) e_rd_n = 1'b0;
    else rw_wr_n = 1'b0;
    tick(8);
    q = bus_lvl;
    e_rd_n = i80;
    rw_wr_n = i80 ? 1'b1 : rw_wr_n;
    tick(6);
    // released lines show garbage, never the last byte
    cs_n = 1'b1;
    d_drv = ~wd;
    tick(4);
  endtask

  // one 4-wire serial byte, msb first, 800 ns link clock
  task automatic spi_byte(input logic sel, input logic dc, input logic [7:0] b);
    cs_n = ~sel;
    dc_sel = dc;
    tick(4);
    for (int i = 7; i >= 0; i--) begin
      d_drv[1:0] = {b[i], 1'b0};
      tick(4);
      d_drv[0] = 1'b1;
      tick(4);
    end
    d_drv[1:0] = {~b[0], 1'b0};
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask

  // i2c start; data line is open drain, oe high pulls it low
  task automatic i2c_start(input logic sa0);
    cs_n = 1'b0;
    dc_sel = sa0;
    tick(4);
    d_oe[1] = 1'b1;
    tick(4);
    d_drv[0] = 1'b0;
  endtask

  // low phase stretched to 8 clk so data settles well clear of both clock edges
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tick(4);
      d_oe[1] = ~b[i];
      tick(4);
      d_drv[0] = 1'b1;
      tick(4);
      d_drv[0] = 1'b0;
    end
    tick(4);
    d_oe[1] = 1'b0;
    tick(4);
    d_drv[0] = 1'b1;
    tick(3);
    ack = ~bus_lvl[1];
    tick(1);
    d_drv[0] = 1'b0;
  endtask

  // stop: data rises while clock is high
  task automatic i2c_stop();
    tick(4);
    d_oe[1] = 1'b1;
    tick(4);
    d_drv[0] = 1'b1;
    tick(4);
    d_oe[1] = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask

  initial park(STRAP_SPI);
endmodule

// [rtl/ohi_host_if.sv]
// host port of a display controller: 6800, 8080, 4-wire serial and i2c
// assumes static straps and a core that accepts one write per cycle
`timescale 1ns/100ps
module ohi_host_if
  import ohi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic reset_in_n,
  input wire logic dc_sel,
  input wire logic rw_wr_n,
  input wire logic e_rd_n,
  input wire logic bus_strap_low,
  input wire logic bus_strap_high,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic [7:0] host_data_bus_oe,
  input wire logic [7:0] rd_data,
  output logic rd_start,
  output ohi_write_s host_wr,
  output logic chip_init,
  output ohi_mode_e bus_mode
);

  // whole state of the port
  typedef struct packed {
    logic locked; // straps taken, filter settled
    logic [1:0] settle; // settle counter
    ohi_mode_e mode; // latched bus type
    logic e_p; // previous enable / read strobe
    logic rw_p; // previous direction / write strobe
    logic sclk_p; // previous serial clock
    logic sdi_p; // previous serial data
    logic rd_active; // parallel read in progress
    logic wr_pending; // parallel write strobe open
    logic [7:0] dout; // bus drive value
    logic [7:0] doe; // bus drive enables
    logic [3:0] bitcnt; // serial bit counter
    logic [7:0] shift; // serial shift register
    ohi_i2c_e iph; // i2c phase
    logic ack; // i2c acknowledge driven
    logic co; // continuation_bit of last control byte
    logic dc_ctl; // data/command from last control byte
    ohi_write_s wr; // byte to the core
    logic rd_start; // read start pulse
    logic init; // chip initialisation level
  } ohi_state_s;

  ohi_state_s st_reg;
  ohi_state_s st_next;
  logic [SY_W-1:0] pins_raw;
  logic [SY_W-1:0] f;

  // every pin passes the synchroniser, data bus included
  assign pins_raw = {host_data_bus_in, bus_strap_high, bus_strap_low, e_rd_n, rw_wr_n, dc_sel, reset_in_n, cs_n};

  ohi_sync #(.W(SY_W), .RST(SY_RESET)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(pins_raw),
    .pin_filt(f)
  );

  // filtered pin views
  logic cs_act;
  logic rst_ok;
  logic dc;
  logic rw;
  logic e;
  logic sclk;
  logic sdi;
  logic [7:0] d;
  logic [1:0] strap;
  assign cs_act = ~f[SY_CS];
  assign rst_ok = f[SY_RST];
  assign dc = f[SY_DC];
  assign rw = f[SY_RW];
  assign e = f[SY_ERD];
  assign d = f[SY_D0 +: 8];
  assign sclk = d[PIN_SCLK];
  assign sdi = d[PIN_SERIAL_DATA_IN];
  assign strap = {f[SY_BSH], f[SY_BSL]};

  // edges against last cycle's filtered levels
  logic e_rise;
  logic e_fall;
  logic rw_rise;
  logic rw_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic scl_hi;
  logic i2c_match;
  assign e_rise = e & ~st_reg.e_p;
  assign e_fall = ~e & st_reg.e_p;
  assign rw_rise = rw & ~st_reg.rw_p;
  assign rw_fall = ~rw & st_reg.rw_p;
  assign sclk_rise = sclk & ~st_reg.sclk_p;
  assign sclk_fall = ~sclk & st_reg.sclk_p;
  assign scl_hi = sclk & st_reg.sclk_p;
  // address byte: six fixed bits, lsb from select pin, write only
  assign i2c_match = (st_reg.shift[7:2] == I2C_ADDR_HI) && (st_reg.shift[1] == dc) && !st_reg.shift[0];

  // strap decode
  function automatic ohi_mode_e strap_mode(input logic [1:0] s);
    unique case (s)
      STRAP_SPI: strap_mode = MODE_SPI;
      STRAP_I2C: strap_mode = MODE_I2C;
      STRAP_6800: strap_mode = MODE_6800;
      default: strap_mode = MODE_8080;
    endcase
  endfunction

  // next state of the whole port
  always_comb begin
    st_next = st_reg;
    st_next.wr.valid = 1'b0;
    st_next.rd_start = 1'b0;
    st_next.e_p = e;
    st_next.rw_p = rw;
    st_next.sclk_p = sclk;
    st_next.sdi_p = sdi;
    st_next.init = ~rst_ok;
    if (!rst_ok) begin
      // chip initialisation: drop everything and re-read straps
      st_next.locked = 1'b0;
      st_next.settle = 2'h0;
      st_next.rd_active = 1'b0;
      st_next.wr_pending = 1'b0;
      st_next.doe = BUS_NONE;
      // a stale read byte must not reach the i2c data half after a mode change
      st_next.dout = BUS_NONE;
      st_next.bitcnt = 4'h0;
      st_next.iph = I2C_IDLE;
      st_next.ack = 1'b0;
    end else if (!st_reg.locked) begin
      // wait for filter, then take the straps once
      if (st_reg.settle == SETTLE_CYC) begin
        st_next.locked = 1'b1;
        st_next.mode = strap_mode(strap);
      end else begin
        st_next.settle = st_reg.settle + 2'h1;
      end
    end else if (!cs_act) begin
      // deselected: abort and release the bus
      st_next.rd_active = 1'b0;
      st_next.wr_pending = 1'b0;
      st_next.doe = BUS_NONE;
      st_next.bitcnt = 4'h0;
      st_next.iph = I2C_IDLE;
      st_next.ack = 1'b0;
    end else begin
      unique case (st_reg.mode)
        MODE_6800: begin
          if (e_rise) begin
            // enable high opens the cycle, direction decides
            if (rw) begin
              st_next.rd_active = 1'b1;
              st_next.dout = rd_data;
              st_next.doe = BUS_ALL;
              st_next.rd_start = 1'b1;
            end else begin
              st_next.wr_pending = 1'b1;
            end
          end else if (e_fall) begin
            // data is taken at the trailing edge, when it is surely stable
            if (st_reg.wr_pending) begin
              st_next.wr = '{valid: 1'b1, is_data: dc, data: d};
            end
            st_next.wr_pending = 1'b0;
            st_next.rd_active = 1'b0;
            st_next.doe = BUS_NONE;
          end
        end
        MODE_8080: begin
          // write strobe low opens a write, rising edge takes the byte
          if (rw_fall) begin
            st_next.wr_pending = 1'b1;
          end else if (rw_rise && st_reg.wr_pending) begin
            st_next.wr = '{valid: 1'b1, is_data: dc, data: d};
            st_next.wr_pending = 1'b0;
          end
          // read strobe low drives the bus until it rises
          if (e_fall) begin
            st_next.rd_active = 1'b1;
            st_next.dout = rd_data;
            st_next.doe = BUS_ALL;
            st_next.rd_start = 1'b1;
          end else if (e_rise) begin
            st_next.rd_active = 1'b0;
            st_next.doe = BUS_NONE;
          end
        end
        MODE_SPI: begin
          // msb first on rising serial clock; select read with the last bit
          if (sclk_rise) begin
            st_next.shift = {st_reg.shift[6:0], sdi};
            if (st_reg.bitcnt == SPI_LAST_BIT) begin
              st_next.wr = '{valid: 1'b1, is_data: dc, data: {st_reg.shift[6:0], sdi}};
              st_next.bitcnt = 4'h0;
            end else begin
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
            end
          end
        end
        MODE_I2C: begin
          if (scl_hi && !sdi && st_reg.sdi_p) begin
            // start or repeated start
            st_next.iph = I2C_ADDR;
            st_next.bitcnt = 4'h0;
            st_next.ack = 1'b0;
            st_next.doe = BUS_NONE;
          end else if (scl_hi && sdi && !st_reg.sdi_p) begin
            // stop
            st_next.iph = I2C_IDLE;
            st_next.ack = 1'b0;
            st_next.doe = BUS_NONE;
          end else if (st_reg.iph != I2C_IDLE) begin
            if (sclk_rise && !st_reg.ack && st_reg.bitcnt < I2C_BYTE_BITS) begin
              st_next.shift = {st_reg.shift[6:0], sdi};
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
            end else if (sclk_fall && st_reg.ack) begin
              // ninth clock over: release data line
              st_next.ack = 1'b0;
              st_next.doe = BUS_NONE;
              st_next.bitcnt = 4'h0;
            end else if (sclk_fall && st_reg.bitcnt == I2C_BYTE_BITS) begin
              // byte complete: pull the output half low to acknowledge
              st_next.ack = 1'b1;
              st_next.dout = BUS_NONE;
              st_next.doe = SDA_OUT_OE;
              unique case (st_reg.iph)
                I2C_ADDR: begin
                  // foreign address or read request: stay silent
                  if (i2c_match) begin
                    st_next.iph = I2C_CTRL;
                  end else begin
                    st_next.iph = I2C_IDLE;
                    st_next.ack = 1'b0;
                    st_next.doe = BUS_NONE;
                  end
                end
                I2C_CTRL: begin
                  st_next.co = st_reg.shift[CTRL_CO_BIT];
                  st_next.dc_ctl = st_reg.shift[CTRL_DC_BIT];
                  st_next.iph = I2C_DATA;
                end
                default: begin
                  // data byte; with continuation set, a control byte follows
                  st_next.wr = '{valid: 1'b1, is_data: st_reg.dc_ctl, data: st_reg.shift};
                  st_next.iph = st_reg.co ? I2C_CTRL : I2C_DATA;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // one register for the whole state, constants under reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{locked: 1'b0, settle: 2'h0, mode: MODE_SPI, e_p: 1'b0, rw_p: 1'b1, sclk_p: 1'b1,
                  sdi_p: 1'b1, rd_active: 1'b0, wr_pending: 1'b0, dout: 8'h00, doe: 8'h00, bitcnt: 4'h0,
                  shift: 8'h00, iph: I2C_IDLE, ack: 1'b0, co: 1'b0, dc_ctl: 1'b0,
                  wr: '{valid: 1'b0, is_data: 1'b0, data: 8'h00}, rd_start: 1'b0, init: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign host_data_bus_out = st_reg.dout;
  assign host_data_bus_oe = st_reg.doe;
  assign host_wr = st_reg.wr;
  assign rd_start = st_reg.rd_start;
  assign chip_init = st_reg.init;
  assign bus_mode = st_reg.mode;

  // checks on the driven side
  logic run;
  assign run = st_reg.locked & rst_ok;

  AST_DESEL_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (st_reg.locked && !cs_act) |=> (host_data_bus_oe == 8'h00) ##1 (host_data_bus_oe == 8'h00))
    else $error("bus driven while deselected");

  AST_DESEL_NO_WRITE: assert property (@(posedge clk) disable iff (reset)
    !cs_act |=> !host_wr.valid)
    else $error("write accepted while deselected");

  AST_INIT_LEVEL: assert property (@(posedge clk) disable iff (reset)
    !rst_ok |=> (chip_init && !host_wr.valid && !st_reg.locked))
    else $error("reset pin low did not initialise");

  AST_8080_WRITE_DC: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_8080 && rw_rise && st_reg.wr_pending)
      |=> (host_wr.valid && host_wr.is_data == $past(dc) && host_wr.data == $past(d)))
    else $error("8080 write lost or data/command wrong");

  AST_6800_READ: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_6800 && e_rise && rw)
      |=> (rd_start && host_data_bus_oe == 8'hFF && host_data_bus_out == $past(rd_data)))
    else $error("6800 read not driven");

  AST_6800_WRITE: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_6800 && e_rise && !rw) |=> (st_reg.wr_pending && !rd_start))
    else $error("6800 write taken as read");

  AST_8080_READ: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_8080 && e_fall) |=> (rd_start && host_data_bus_oe == 8'hFF))
    else $error("8080 read not driven");

  AST_I2C_PIN: assert property (@(posedge clk) disable iff (reset)
    (st_reg.mode == MODE_I2C) |-> ((host_data_bus_oe & 8'hFB) == 8'h00 && host_data_bus_out[2] == 1'b0))
    else $error("i2c drives a pin other than data out");

  AST_STRAP_MAP: assert property (@(posedge clk) disable iff (reset)
    (!st_reg.locked && rst_ok && st_reg.settle == SETTLE_CYC) |=> (bus_mode == strap_mode($past(strap))))
    else $error("bus type does not follow straps");

  AST_I2C_ADDR_ACK: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_I2C && st_reg.iph == I2C_ADDR && sclk_fall && !st_reg.ack
      && !scl_hi && st_reg.bitcnt == 4'h8) |=> (host_data_bus_oe[2] == $past(i2c_match)))
    else $error("i2c address acknowledge wrong");

  AST_SPI_BYTE: assert property (@(posedge clk) disable iff (reset)
    (run && cs_act && st_reg.mode == MODE_SPI && sclk_rise && st_reg.bitcnt == 4'h7)
      |=> (host_wr.valid && host_wr.data == {$past(st_reg.shift[6:0]), $past(sdi)}))
    else $error("serial byte not delivered");

endmodule

// [rtl/ohi_pkg.sv]
// constants, types and carriers for the display host interface
// assumes a single 10 MHz clock; every pin is synchronised before use
package ohi_pkg;

  // bus mode from the two strap pins {strap_high, strap_low}
  typedef enum logic [1:0] {MODE_SPI, MODE_I2C, MODE_6800, MODE_8080} ohi_mode_e;

  // i2c transfer phases
  typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_CTRL, I2C_DATA} ohi_i2c_e;

  // strap codes, {bus_strap_high, bus_strap_low}
  localparam logic [1:0] STRAP_SPI = 2'h0;
  localparam logic [1:0] STRAP_I2C = 2'h1;
  localparam logic [1:0] STRAP_6800 = 2'h2;
  localparam logic [1:0] STRAP_8080 = 2'h3;

  // positions in the synchronised pin vector
  localparam int SY_CS = 0;
  localparam int SY_RST = 1;
  localparam int SY_DC = 2;
  localparam int SY_RW = 3;
  localparam int SY_ERD = 4;
  localparam int SY_BSL = 5;
  localparam int SY_BSH = 6;
  localparam int SY_D0 = 7;
  localparam int SY_W = 15;
  // idle pin levels: selects off, reset released, strobes idle, data lines high
  localparam logic [14:0] SY_RESET = 15'h7F8B;

  // cycles for the filter to settle before straps are trusted
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // serial pin roles on the data bus
  localparam int PIN_SCLK = 0;
  localparam int PIN_SERIAL_DATA_IN = 1;
  localparam int PIN_SDA_OUT = 2;
  localparam logic [7:0] SDA_OUT_OE = 8'h04;
  localparam logic [7:0] BUS_ALL = 8'hFF;
  localparam logic [7:0] BUS_NONE = 8'h00;

  // bit counts
  localparam logic [3:0] SPI_LAST_BIT = 4'h7;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // i2c slave address upper six bits, low bit from the address select pin
  localparam logic [5:0] I2C_ADDR_HI = 6'h1E;
  // control byte fields
  localparam int CTRL_CO_BIT = 7;
  localparam int CTRL_DC_BIT = 6;

  // one received byte handed to the core
  typedef struct packed {
    logic valid;
    logic is_data;
    logic [7:0] data;
  } ohi_write_s;

endpackage

// [rtl/ohi_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module ohi_sync
  import ohi_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_filt
);

  // whole state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt; // accepted level
  } ohi_sync_s;

  ohi_sync_s st_reg;
  ohi_sync_s st_next;

  // a bit changes only once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = (st_reg.s2 & st_reg.s3) | (st_reg.filt & (st_reg.s2 ^ st_reg.s3));
  end

  // register the state, constants only under reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{s1: RST, s2: RST, s3: RST, filt: RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_filt = st_reg.filt;

endmodule
